// >>> lfs_pkg.sv
package lfs_pkg;

  // Bus geometry and answers
  localparam int         AXI_AW      = 8;
  localparam int         AXI_DW      = 32;
  localparam int         AXI_SW      = AXI_DW / 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets; CFG and LUT banks hold one word per slice
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CFG  = 8'h10;
  localparam logic [7:0] OFS_LUT  = 8'h20;
  localparam logic [7:0] BANK_MSK = 8'hF0;
  localparam int         IDX_LSB  = 2;
  localparam int         IDX_W    = 2;

  // Fabric geometry
  localparam int NUM_SLICES = 4;
  localparam int NUM_PAIRS  = 2;
  localparam int LUT_IN     = 4;
  localparam int LUT_WORDS  = 16;
  localparam int RAM_SLICE  = 2;
  localparam int CTRL_W     = 3;
  localparam int CFG_W      = 10;

  // Ripple operations
  typedef enum logic [2:0] {
    OP_ADD    = 3'h0,
    OP_SUB    = 3'h1,
    OP_ADDSUB = 3'h2,
    OP_CNTUP  = 3'h3,
    OP_CNTDN  = 3'h4,
    OP_CNTUD  = 3'h5,
    OP_CMP    = 3'h6,
    OP_MUL    = 3'h7
  } lfs_op_t;

  typedef struct packed {
    logic pdp;
    logic ramEn;
    logic run;
  } lfs_ctrl_t;

  typedef struct packed {
    logic [1:0] srVal;
    logic       srAsync;
    logic       negEdge;
    logic       ffDirect;
    logic       lut5En;
    logic       ripple;
    lfs_op_t    op;
  } lfs_cfg_t;

  // Routed data inputs of one slice
  typedef struct packed {
    logic [LUT_IN-1:0] lut1In;
    logic [LUT_IN-1:0] lut0In;
    logic [1:0]        ffDirectIn;
    logic              sel;
  } lfs_slice_in_t;

  typedef struct packed {
    logic                                    awGot;
    logic                                    wGot;
    logic                                    awRdy;
    logic                                    wRdy;
    logic                                    bValid;
    logic                                    arRdy;
    logic                                    rValid;
    logic [AXI_AW-1:0]                       awAddr;
    logic [AXI_DW-1:0]                       wData;
    logic [AXI_SW-1:0]                       wStrb;
    logic [1:0]                              bResp;
    logic [1:0]                              rResp;
    logic [AXI_DW-1:0]                       rData;
    lfs_ctrl_t                               ctrl;
    lfs_cfg_t [NUM_SLICES-1:0]               cfg;
    logic [NUM_SLICES-1:0][2*LUT_WORDS-1:0]  lut;
    logic [NUM_SLICES-1:0][1:0]              ff;
    logic [NUM_PAIRS-1:0]                    clkPrev;
    logic [NUM_SLICES-1:0]                   fLow;
    logic [NUM_SLICES-1:0]                   fHigh;
    logic                                    cOut;
  } lfs_state_t;

  localparam lfs_state_t ST_RST = '0;

endpackage : lfs_pkg

// >>> lfs_function_unit.sv
module lfs_function_unit
  import lfs_pkg::*;
(
  input  logic                                mclk,
  input  logic                                nrst,
  input  logic                                clkEn,
  input  logic [AXI_AW-1:0]                   s_axi_awaddr,
  input  logic                                s_axi_awvalid,
  output logic                                s_axi_awready,
  input  logic [AXI_DW-1:0]                   s_axi_wdata,
  input  logic [AXI_SW-1:0]                   s_axi_wstrb,
  input  logic                                s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  logic                                s_axi_bready,
  input  logic [AXI_AW-1:0]                   s_axi_araddr,
  input  logic                                s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [AXI_DW-1:0]                   s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  logic                                s_axi_rready,
  input  lfs_slice_in_t [NUM_SLICES-1:0]      sliceIn,
  input  logic [NUM_PAIRS-1:0]                sliceClock,
  input  logic [NUM_PAIRS-1:0]                sliceCe,
  input  logic [NUM_PAIRS-1:0]                localSetReset,
  input  logic                                carryIn,
  output logic [NUM_SLICES-1:0]               combOutLow,
  output logic [NUM_SLICES-1:0]               combOutHigh,
  output logic [NUM_SLICES-1:0][1:0]          ffOut,
  output logic                                carryOut
);

  lfs_state_t                       st_r;
  lfs_state_t                       st_nxt;
  logic [NUM_SLICES-1:0][LUT_IN-1:0] rdA;
  logic [NUM_SLICES-1:0][LUT_IN-1:0] rdB;
  logic [NUM_SLICES-1:0]            l0;
  logic [NUM_SLICES-1:0]            l1;
  logic [NUM_SLICES-1:0]            f0;
  logic [NUM_SLICES-1:0]            f1;
  logic [NUM_SLICES-1:0]            actE;
  logic [NUM_SLICES-1:0]            gen;
  logic [NUM_SLICES-1:0]            prop;
  logic [NUM_SLICES:0]              cy;
  logic [NUM_SLICES-1:0][1:0]       opA;
  logic [NUM_SLICES-1:0][1:0]       opB;
  logic [NUM_SLICES-1:0][1:0]       x;
  logic [NUM_SLICES-1:0][1:0]       y;
  logic [NUM_SLICES-1:0][1:0]       d;
  logic [NUM_SLICES-1:0][2:0]       tot;
  logic [NUM_SLICES-1:0][2:0]       sum;
  logic [NUM_SLICES-1:0][1:0]       initVec;
  logic [LUT_IN-1:0]                ramWAddr;
  logic                             ramWe;
  logic                             allLogic;
  logic                             awHs;
  logic                             wHs;
  logic                             axiWr;
  logic                             rdHit;
  logic [AXI_DW-1:0]                rdOld;
  logic [AXI_DW-1:0]                wm;
  logic                             arHit;
  logic [AXI_DW-1:0]                arWord;

  // Register view shared by the read path and the write merge
  function automatic logic [AXI_DW:0] regRead(input lfs_state_t st,
                                              input logic [AXI_AW-1:0] a);
    logic [IDX_W-1:0] i;
    i = a[IDX_LSB +: IDX_W];
    regRead = '0;
    if (a == OFS_CTRL) begin
      regRead = {1'b1, AXI_DW'(st.ctrl)};
    end else if (a == OFS_STAT) begin
      regRead = {1'b1, 15'h0000, st.cOut, st.ff, st.fHigh, st.fLow};
    end else if ((a & BANK_MSK) == OFS_CFG && a[1:0] == 2'h0) begin
      regRead = {1'b1, AXI_DW'(st.cfg[i])};
    end else if ((a & BANK_MSK) == OFS_LUT && a[1:0] == 2'h0) begin
      regRead = {1'b1, st.lut[i]};
    end
  endfunction : regRead

  // Whole next state; slices evaluate in carry order so cy ripples
  always_comb begin
    st_nxt   = st_r;
    axiWr    = 1'b0;
    allLogic = 1'b1;
    ramWAddr = sliceIn[RAM_SLICE].lut0In;
    cy[0]    = carryIn;
    for (int s = 0; s < NUM_SLICES; s++) begin
      // Edge of the pair's shared clock, polarity per slice
      actE[s] = st_r.cfg[s].negEdge ?
                (st_r.clkPrev[s/2] && !sliceClock[s/2]) :
                (!st_r.clkPrev[s/2] && sliceClock[s/2]);
      // Storage slices read at the write address unless pseudo-dual-port
      if (st_r.ctrl.ramEn && s < RAM_SLICE && !st_r.ctrl.pdp) begin
        rdA[s] = ramWAddr;
        rdB[s] = ramWAddr;
      end else if (st_r.ctrl.ramEn && s < RAM_SLICE) begin
        rdA[s] = sliceIn[s].lut0In;
        rdB[s] = sliceIn[s].lut0In;
      end else begin
        rdA[s] = sliceIn[s].lut0In;
        rdB[s] = sliceIn[s].lut1In;
      end
      l0[s] = st_r.lut[s][{1'b0, rdA[s]}];
      l1[s] = st_r.lut[s][{1'b1, rdB[s]}];
      opA[s] = {sliceIn[s].lut1In[0], sliceIn[s].lut0In[0]};
      opB[s] = {sliceIn[s].lut1In[1], sliceIn[s].lut0In[1]};
      // Ripple operand selection; sel is the dynamic control
      unique case (st_r.cfg[s].op)
        OP_ADD: begin
          x[s] = opA[s];
          y[s] = opB[s];
        end
        OP_SUB: begin
          x[s] = opA[s];
          y[s] = ~opB[s];
        end
        OP_ADDSUB: begin
          x[s] = opA[s];
          y[s] = sliceIn[s].sel ? ~opB[s] : opB[s];
        end
        OP_CNTUP: begin
          x[s] = st_r.ff[s];
          y[s] = 2'h0;
        end
        OP_CNTDN: begin
          x[s] = st_r.ff[s];
          y[s] = 2'h3;
        end
        OP_CNTUD: begin
          x[s] = st_r.ff[s];
          y[s] = sliceIn[s].sel ? 2'h3 : 2'h0;
        end
        OP_CMP: begin
          x[s] = opA[s];
          y[s] = ~opB[s];
        end
        OP_MUL: begin
          x[s] = {1'b0, opA[s][0] & opB[s][1]};
          y[s] = {1'b0, opA[s][1] & opB[s][0]};
        end
      endcase
      tot[s] = {1'b0, x[s]} + {1'b0, y[s]};
      sum[s] = tot[s] + {2'h0, cy[s]};
      // Multiply cells carry out of bit 0, the rest out of bit 1
      gen[s]  = (st_r.cfg[s].op == OP_MUL) ? tot[s][1] : tot[s][2];
      prop[s] = (st_r.cfg[s].op == OP_MUL) ? tot[s][0] : &tot[s][1:0];
      if (st_r.ctrl.ramEn && s <= RAM_SLICE) begin
        // Storage and address slices pass the carry through unchanged
        f0[s]     = (s == RAM_SLICE) ? 1'b0 : l0[s];
        f1[s]     = (s == RAM_SLICE) ? 1'b0 : l1[s];
        cy[s + 1] = cy[s];
      end else if (st_r.cfg[s].ripple) begin
        allLogic  = 1'b0;
        cy[s + 1] = gen[s] | (prop[s] & cy[s]);
        if (st_r.cfg[s].op == OP_CMP) begin
          // Chained carry is A >= B; sel picks the local relation
          f0[s] = cy[s + 1];
          f1[s] = sliceIn[s].sel ? (opA[s] <= opB[s]) : (opA[s] != opB[s]);
        end else if (st_r.cfg[s].op == OP_MUL) begin
          f0[s] = sum[s][0];
          f1[s] = l1[s];
        end else begin
          f0[s] = sum[s][0];
          f1[s] = sum[s][1];
        end
      end else begin
        cy[s + 1] = cy[s];
        f0[s]     = (st_r.cfg[s].lut5En && sliceIn[s].sel) ? l1[s] : l0[s];
        f1[s]     = l1[s];
      end
      // Flip-flop data path
      d[s] = st_r.cfg[s].ffDirect ? sliceIn[s].ffDirectIn : {f1[s], f0[s]};
      if (st_r.cfg[s].ripple && st_r.cfg[s].op inside {OP_CNTUP, OP_CNTDN, OP_CNTUD}
          && sliceIn[s].lut0In[2]) begin
        d[s] = sliceIn[s].ffDirectIn;
      end
      if (st_r.cfg[s].ripple && st_r.cfg[s].op == OP_MUL) begin
        // Serial shift: one bit per cycle, or two when sel is high
        d[s] = {sliceIn[s].sel ? sliceIn[s].ffDirectIn[1] : st_r.ff[s][0],
                sliceIn[s].ffDirectIn[0]};
      end
      initVec[s] = st_r.cfg[s].srVal;
      // Idle fabric sits at its set/reset value so run starts known
      if (!st_r.ctrl.run) begin
        st_nxt.ff[s] = st_r.cfg[s].srVal;
      end else if (localSetReset[s/2] && (st_r.cfg[s].srAsync || actE[s])) begin
        st_nxt.ff[s] = st_r.cfg[s].srVal;
      end else if (actE[s] && sliceCe[s/2]) begin
        st_nxt.ff[s] = d[s];
      end
      st_nxt.fLow[s]  = f0[s];
      st_nxt.fHigh[s] = f1[s];
    end
    st_nxt.cOut    = cy[NUM_SLICES];
    st_nxt.clkPrev = sliceClock;

    // Slice 2 control: write enable on the storage pair's clock edge
    ramWe = st_r.ctrl.ramEn && st_r.ctrl.run &&
            sliceIn[RAM_SLICE].ffDirectIn[0] && actE[0];
    if (ramWe) begin
      for (int s = 0; s < RAM_SLICE; s++) begin
        st_nxt.lut[s][{1'b0, ramWAddr}] = sliceIn[s].ffDirectIn[0];
        st_nxt.lut[s][{1'b1, ramWAddr}] = sliceIn[s].ffDirectIn[1];
      end
    end

    // Write channels; address and data may arrive in either order
    awHs = s_axi_awvalid && st_r.awRdy;
    wHs  = s_axi_wvalid && st_r.wRdy;
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (awHs) begin
      st_nxt.awGot  = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (wHs) begin
      st_nxt.wGot  = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    {rdHit, rdOld} = regRead(st_nxt, st_nxt.awAddr);
    for (int b = 0; b < AXI_SW; b++) begin
      wm[8*b +: 8] = st_nxt.wStrb[b] ? st_nxt.wData[8*b +: 8] : rdOld[8*b +: 8];
    end
    if (st_nxt.awGot && st_nxt.wGot && !st_nxt.bValid) begin
      st_nxt.awGot  = 1'b0;
      st_nxt.wGot   = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = rdHit ? RESP_OKAY : RESP_SLVERR;
      axiWr         = rdHit;
      // Status is read-only, a write there is accepted and dropped
      if (st_nxt.awAddr == OFS_CTRL) begin
        st_nxt.ctrl = lfs_ctrl_t'(wm[CTRL_W-1:0]);
      end else if ((st_nxt.awAddr & BANK_MSK) == OFS_CFG) begin
        st_nxt.cfg[st_nxt.awAddr[IDX_LSB +: IDX_W]] = lfs_cfg_t'(wm[CFG_W-1:0]);
      end else if ((st_nxt.awAddr & BANK_MSK) == OFS_LUT) begin
        // Table preload; wins over a fabric RAM write in the same cycle
        st_nxt.lut[st_nxt.awAddr[IDX_LSB +: IDX_W]] = wm;
      end
    end
    st_nxt.awRdy = !st_nxt.awGot && !st_nxt.bValid;
    st_nxt.wRdy  = !st_nxt.wGot && !st_nxt.bValid;

    // Read channel answers one cycle after the address is taken
    {arHit, arWord} = regRead(st_r, s_axi_araddr);
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arRdy) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData  = arWord;
      st_nxt.rResp  = arHit ? RESP_OKAY : RESP_SLVERR;
    end
    st_nxt.arRdy = !st_nxt.rValid;
  end

  // Global enable freezes everything, the bus included
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RST;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // Every output is a state bit
  assign s_axi_awready = st_r.awRdy;
  assign s_axi_wready  = st_r.wRdy;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_arready = st_r.arRdy;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign s_axi_rvalid  = st_r.rValid;
  assign combOutLow    = st_r.fLow;
  assign combOutHigh   = st_r.fHigh;
  assign ffOut         = st_r.ff;
  assign carryOut      = st_r.cOut;

  // Bus answers hold until taken
  a_bvalid_hold: assert property (@(posedge mclk) disable iff (!nrst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");

  a_read_answer: assert property (@(posedge mclk) disable iff (!nrst)
    s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");

  a_ffs_idle_init: assert property (@(posedge mclk) disable iff (!nrst)
    !st_r.ctrl.run && clkEn |=> ffOut == $past(initVec))
    else $error("idle flip-flops not at set/reset value");

  a_ram_slice_off: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.ctrl.ramEn && clkEn |=> !combOutLow[RAM_SLICE] && !combOutHigh[RAM_SLICE])
    else $error("address slice drives logic in RAM mode");

  a_carry_pass: assert property (@(posedge mclk) disable iff (!nrst)
    allLogic && clkEn |=> carryOut == $past(carryIn))
    else $error("carry chain altered with no ripple slice");

  a_ce_hold: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.ctrl.run && !sliceCe[0] && !localSetReset[0] && clkEn && !axiWr
    |=> $stable(ffOut[0]) && $stable(ffOut[1]))
    else $error("pair 0 flip-flops moved with enable low");

  a_async_clear: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.ctrl.run && st_r.cfg[0].srAsync && localSetReset[0] && clkEn && !axiWr
    |=> ffOut[0] == st_r.cfg[0].srVal)
    else $error("asynchronous set/reset not applied");

  a_lut5_mux: assert property (@(posedge mclk) disable iff (!nrst)
    !st_r.ctrl.ramEn && !st_r.cfg[3].ripple && st_r.cfg[3].lut5En &&
    sliceIn[3].sel && clkEn |=> combOutLow[3] == combOutHigh[3])
    else $error("5-input select did not pick the high table");

  // Falling-edge capture of a direct input
  sequence s_fallEdge0;
    st_r.ctrl.run && st_r.cfg[0].negEdge && st_r.clkPrev[0] && !sliceClock[0];
  endsequence

  sequence s_plainCapture0;
    sliceCe[0] && !localSetReset[0] && st_r.cfg[0].ffDirect &&
    !st_r.cfg[0].ripple && clkEn && !axiWr;
  endsequence

  a_neg_edge_cap: assert property (@(posedge mclk) disable iff (!nrst)
    s_fallEdge0 and s_plainCapture0 |=> ffOut[0] == $past(sliceIn[0].ffDirectIn))
    else $error("falling edge capture missed");

  sequence s_ramWrite;
    ramWe && clkEn && !axiWr;
  endsequence

  a_ram_write: assert property (@(posedge mclk) disable iff (!nrst)
    s_ramWrite |=> st_r.lut[1][{1'b1, $past(ramWAddr)}] == $past(sliceIn[1].ffDirectIn[1]))
    else $error("distributed RAM write lost");

endmodule : lfs_function_unit

// >>> lfs_fabric_model.sv
// Stands in for routing that drives the pair controls and the carry chain
module lfs_fabric_model
  import lfs_pkg::*;
(
  input  logic                 mclk,
  output logic [NUM_PAIRS-1:0] sliceClock,
  output logic [NUM_PAIRS-1:0] sliceCe,
  output logic [NUM_PAIRS-1:0] localSetReset,
  output logic                 carryIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // Slice clocks idle low so no edge is seen straight out of reset
  initial begin
    sliceClock    = '0;
    sliceCe       = '1;
    localSetReset = '0;
    carryIn       = 1'b0;
  end

  // One clock, enable and set/reset for each slice pair
  task automatic drive(input int p, input logic ce, input logic local_set_reset, input logic clk);
    @(posedge mclk);
    sliceCe[p]       <= ce;
    localSetReset[p] <= local_set_reset;
    sliceClock[p]    <= clk;
  endtask : drive

  // Carry into slice 0 from the neighbouring unit
  task automatic carry(input logic c);
    @(posedge mclk);
    carryIn <= c;
  endtask : carry
endmodule : lfs_fabric_model

// >>> tb_lfs_function_unit.sv
module tb_lfs_function_unit;
  import lfs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic [1:0] kind; logic [35:0] exp; logic [35:0] msk;} lfs_note_t;

  logic                             mclk, nrst, probe;
  logic                             awValid, wValid, bReady, arValid, rReady;
  logic                             awReady, wReady, bValid, arReady, rValid;
  logic [AXI_AW-1:0]                awAddr, arAddr;
  logic [AXI_DW-1:0]                wData, rData;
  logic [1:0]                       bResp, rResp;
  lfs_slice_in_t [NUM_SLICES-1:0]   sliceIn, si;
  logic [NUM_PAIRS-1:0]             sliceClock, sliceCe, localSetReset;
  logic                             carryIn, carryOut;
  logic [NUM_SLICES-1:0]            combOutLow, combOutHigh, fl, fh;
  logic [NUM_SLICES-1:0][1:0]       ffOut;
  logic [31:0]                      seed, lut [NUM_SLICES];
  logic [7:0]                       a, b;
  logic [3:0]                       ra;
  logic [8:0]                       sum;
  logic [6:0]                       stepTab [11];
  int                               n_errors, cmp_count, cycles;
  lfs_note_t                        q [$];

  lfs_function_unit i_lfs_function_unit (.mclk(mclk), .nrst(nrst), .clkEn(1'b1),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sliceIn(sliceIn), .sliceClock(sliceClock), .sliceCe(sliceCe), .localSetReset(localSetReset),
    .carryIn(carryIn), .combOutLow(combOutLow), .combOutHigh(combOutHigh), .ffOut(ffOut),
    .carryOut(carryOut));

  lfs_fabric_model i_lfs_fabric_model (.mclk(mclk), .sliceClock(sliceClock), .sliceCe(sliceCe),
    .localSetReset(localSetReset), .carryIn(carryIn));

  // Free-running system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Oldest note is compared with whatever result shows up; masks skip unowned bits
  task automatic pop(input logic [1:0] k, input logic [35:0] seen);
    lfs_note_t n;
    if (q.size() == 0) n = '0;
    else n = q.pop_front();
    check({n.kind, seen & n.msk}, {k, n.exp & n.msk});
  endtask : pop

  always @(posedge mclk) begin
    if (bValid && bReady) pop(2'h1, {34'h0, bResp});
    if (rValid && rReady) pop(2'h0, {2'h0, rResp, rData});
    if (probe) pop(2'h2, {19'h0, carryOut, ffOut, combOutHigh, combOutLow});
    cycles++;
    if (cycles > 8000) begin
      n_errors++;
      test_done();
    end
  end

  // Write holds each channel until taken, bready until the answer
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    q.push_back({2'h1, 34'h0, r, 36'h3});
    @(posedge mclk);
    awAddr <= ad;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    q.push_back({2'h0, 2'h0, r, d, 36'hFFFFFFFFF});
    @(posedge mclk);
    arAddr <= ad;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
  endtask : rd

  // Outputs are registered, so the probe lands one cycle after the inputs settle
  task automatic fab(input logic [16:0] e, input logic [16:0] m);
    q.push_back({2'h2, 19'h0, e, 19'h0, m});
    @(posedge mclk);
    probe <= 1'b1;
    @(posedge mclk);
    probe <= 1'b0;
  endtask : fab

  // Steps {direct, enable, setReset, slice clock, expected flip-flops}
  initial begin
    {awValid, wValid, bReady, arValid, rReady, probe, nrst} = '0;
    {awAddr, arAddr, wData, sliceIn} = '0;
    seed = 32'h6B24;
    stepTab = '{7'h36, 7'h32, 7'h35, 7'h71, 7'h65, 7'h7D, 7'h79, 7'h7E, 7'h31, 7'h75, 7'h6E};
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_CFG, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h08, 32'h1, RESP_SLVERR);
    wr(OFS_STAT, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    $display("test registers done");
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_CFG + 8'hC, 32'h10, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      for (int s = 0; s < NUM_SLICES; s++) begin
        lut[s] = xs();
        wr(OFS_LUT + 8'(4 * s), lut[s], RESP_OKAY);
      end
      rd(OFS_LUT + 8'h4, lut[1], RESP_OKAY);
      si = 44'({xs(), xs()});
      @(posedge mclk);
      sliceIn <= si;
      for (int s = 0; s < NUM_SLICES; s++) begin
        fl[s] = lut[s][si[s].lut0In];
        fh[s] = lut[s][16 + si[s].lut1In];
      end
      if (si[3].sel) fl[3] = fh[3];
      fab({9'h0, fh, fl}, 17'h000FF);
    end
    $display("test logic done");
    // Whole unit as an 8-bit chain: add, subtract, compare; the last two need carry-in high
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < NUM_SLICES; s++) begin
        wr(OFS_CFG + 8'(4 * s), (k == 2) ? 32'hE : 32'h8 + 32'(k), RESP_OKAY);
      end
      i_lfs_fabric_model.carry(k != 0);
      for (int i = 0; i < 6; i++) begin
        si = 44'({xs(), xs()});
        @(posedge mclk);
        sliceIn <= si;
        for (int s = 0; s < NUM_SLICES; s++) begin
          a[2*s+:2] = {si[s].lut1In[0], si[s].lut0In[0]};
          b[2*s+:2] = {si[s].lut1In[1], si[s].lut0In[1]};
        end
        // Concatenation keeps the inversion at 8 bits, so bit 8 is the true carry out
        sum = 9'(a) + {1'b0, (k != 0) ? ~b : b} + 9'(k != 0);
        for (int s = 0; s < NUM_SLICES; s++) begin
          {fh[s], fl[s]} = sum[2*s+:2];
          // Compare: low output is A >= B over slices up to s, high output the local relation
          if (k == 2) begin
            fl[s] = 8'(a << (6 - 2 * s)) >= 8'(b << (6 - 2 * s));
            fh[s] = si[s].sel ? (a[2*s+:2] <= b[2*s+:2]) : (a[2*s+:2] != b[2*s+:2]);
          end
        end
        fab({sum[8], 8'h0, fh, fl}, 17'h100FF);
      end
    end
    $display("test ripple done");
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    for (int s = 0; s < NUM_SLICES; s++) wr(OFS_CFG + 8'(4 * s), 32'h0, RESP_OKAY);
    wr(OFS_CFG, 32'h220, RESP_OKAY);
    for (int i = 0; i < 11; i++) begin
      if (i == 2) wr(OFS_CTRL, 32'h1, RESP_OKAY);
      if (i == 8) wr(OFS_CFG, 32'h260, RESP_OKAY);
      if (i == 10) wr(OFS_CFG, 32'h2A0, RESP_OKAY);
      @(posedge mclk);
      sliceIn[0].ffDirectIn <= stepTab[i][6:5];
      i_lfs_fabric_model.drive(0, stepTab[i][4], stepTab[i][3], stepTab[i][2]);
      repeat (3) @(posedge mclk);
      fab({7'h0, stepTab[i][1:0], 8'h0}, 17'h00300);
    end
    $display("test flip-flops done");
    // Distributed RAM: slice 2 addresses slices 0 and 1, single-port then pseudo-dual-port
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    i_lfs_fabric_model.drive(0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr(OFS_CTRL, 32'h7, RESP_OKAY);
      si = 44'({xs(), xs()});
      si[RAM_SLICE].ffDirectIn[0] = 1'b1;
      @(posedge mclk);
      sliceIn <= si;
      i_lfs_fabric_model.drive(0, 1'b1, 1'b0, 1'b1);
      i_lfs_fabric_model.drive(0, 1'b1, 1'b0, 1'b0);
      for (int s = 0; s < NUM_SLICES; s++) begin
        ra = (s < RAM_SLICE && i < 2) ? si[RAM_SLICE].lut0In : si[s].lut0In;
        if (s < RAM_SLICE) begin
          lut[s][si[RAM_SLICE].lut0In] = si[s].ffDirectIn[0];
          lut[s][16 + si[RAM_SLICE].lut0In] = si[s].ffDirectIn[1];
        end
        fl[s] = lut[s][ra];
        fh[s] = lut[s][16 + ((s < RAM_SLICE) ? ra : si[s].lut1In)];
      end
      {fh[RAM_SLICE], fl[RAM_SLICE]} = 2'b00;
      fab({9'h0, fh, fl}, 17'h000FF);
      rd(OFS_LUT, lut[0], RESP_OKAY);
    end
    $display("test RAM done");
    repeat (4) @(posedge mclk);
    check(36'(q.size()), 36'h0);
    test_done();
  end
endmodule : tb_lfs_function_unit
